// ### pmce_cfg.svh
/*
 * Constants of the power measurement calculation engine: field widths,
 * sequencing codes and reset values.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef PMCE_CFG_SVH
`define PMCE_CFG_SVH

`define PMCE_ADC_W 20
`define PMCE_CAL_W 15
`define PMCE_CUR_W 24
`define PMCE_PWR_W 24
`define PMCE_ACC_W 40
`define PMCE_SUM_W 32
`define PMCE_AVG_W 11
`define PMCE_CNT_ONE 11'h001
`define PMCE_CH_SHUNT 2'h0
`define PMCE_CH_BUS 2'h1
`define PMCE_CH_TEMP 2'h2
`define PMCE_RESULT_RST 24'h000000
`define PMCE_ACC_RST 40'h0000000000

`endif

// ### pmce_pkg.sv
/*
 * Types shared by the calculation engine.
 * Assumes pmce_cfg.svh is on the include path.
 */
`include "pmce_cfg.svh"

package pmce_pkg;
    typedef enum logic [1:0] {
        PMCE_ST_IDLE = 2'b00,
        PMCE_ST_CONV = 2'b01,
        PMCE_ST_WAIT = 2'b10,
        PMCE_ST_LOAD = 2'b11
    } pmce_state_t;
endpackage

// ### pmce_avg_acc.sv
/*
 * One averaging accumulator: sums samples and divides by the count.
 * Assumes samples are signed and the count is any value from 1 to 2047,
 * not only a power of two; division is combinational and registered by the caller.
 */
`include "pmce_cfg.svh"

module pmce_avg_acc (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic add,
    input wire logic signed [`PMCE_CUR_W-1:0] sample,
    input wire logic [`PMCE_AVG_W-1:0] count,
    output logic signed [`PMCE_CUR_W-1:0] mean
);
    logic signed [`PMCE_SUM_W-1:0] sum_q;
    logic signed [`PMCE_SUM_W-1:0] sum_new;
    logic signed [`PMCE_SUM_W-1:0] sum_all;
    logic signed [`PMCE_SUM_W-1:0] div;
    logic signed [`PMCE_SUM_W-1:0] quot;

    assign sum_new = sum_q + `PMCE_SUM_W'(sample);
    // Only this quantity's own sample may join the mean in this cycle
    assign sum_all = add ? sum_new : sum_q;
    // A count of zero is taken as one rather than dividing by zero
    assign div = (count == '0) ? 32'sh00000001 : $signed({21'h00000, count});

    // Clear wins over add; the final sample already sits in the mean
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sum_q <= '0;
        else if (clr)
            sum_q <= '0;
        else if (add)
            sum_q <= sum_new;
    end

    assign quot = sum_all / div;
    assign mean = quot[`PMCE_CUR_W-1:0];
endmodule

// ### pmce_engine.sv
/*
 * Background calculation engine: sequences one shared ADC over shunt,
 * bus and temperature, averages, derives current, power, energy, charge.
 * Assumes the ADC is same-clock logic: it takes adc_start, later pulses
 * adc_done with adc_data for the channel on adc_sel. Config inputs are
 * static while a sequence runs; a change is signalled by cfg_write.
 */
`include "pmce_cfg.svh"

module pmce_engine (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cfg_write,
    input wire logic cfg_continuous,
    input wire logic cfg_en_shunt,
    input wire logic cfg_en_bus,
    input wire logic cfg_en_temp,
    input wire logic [`PMCE_AVG_W-1:0] cfg_avg_count,
    input wire logic [`PMCE_CAL_W-1:0] shunt_cal,
    input wire logic flag_read,
    output logic adc_start,
    output logic [1:0] adc_sel,
    input wire logic adc_done,
    input wire logic signed [`PMCE_ADC_W-1:0] adc_data,
    output logic signed [`PMCE_CUR_W-1:0] current_out,
    output logic signed [`PMCE_CUR_W-1:0] vbus_out,
    output logic signed [`PMCE_CUR_W-1:0] temp_out,
    output logic [`PMCE_PWR_W-1:0] power_out,
    output logic signed [`PMCE_ACC_W-1:0] energy_out,
    output logic signed [`PMCE_ACC_W-1:0] charge_out,
    output logic accum_valid,
    output logic conversion_done_flag
);
    pmce_pkg::pmce_state_t state_q;
    logic [1:0] ch_q;
    logic [`PMCE_AVG_W-1:0] n_q;
    logic signed [`PMCE_CUR_W-1:0] cur_now_q;
    logic [`PMCE_PWR_W-1:0] pwr_now_q;
    logic signed [`PMCE_CUR_W-1:0] cur_sample;
    logic signed [`PMCE_CUR_W-1:0] bus_sample;
    logic signed [`PMCE_CUR_W-1:0] tmp_sample;
    logic signed [`PMCE_CUR_W-1:0] cur_mean;
    logic signed [`PMCE_CUR_W-1:0] bus_mean;
    logic signed [`PMCE_CUR_W-1:0] tmp_mean;
    logic signed [47:0] cur_prod;
    logic [47:0] pwr_prod;
    logic [47:0] pwr_mean_prod;
    logic [1:0] ch_next;
    logic last_ch;
    logic last_sample;
    logic cal_zero;
    logic any_en;
    logic clr_avg;
    logic load;
    logic done_shunt;
    logic done_bus;
    logic done_temp;

    assign cal_zero = (shunt_cal == '0);
    assign any_en = cfg_en_shunt | cfg_en_bus | cfg_en_temp;

    // Next enabled channel after ch_q, in shunt, bus, temp order
    always_comb
    begin
        ch_next = `PMCE_CH_SHUNT;
        last_ch = 1'b1;
        if (ch_q == `PMCE_CH_SHUNT && cfg_en_bus)
        begin
            ch_next = `PMCE_CH_BUS;
            last_ch = 1'b0;
        end
        else if (ch_q != `PMCE_CH_TEMP && cfg_en_temp)
        begin
            ch_next = `PMCE_CH_TEMP;
            last_ch = 1'b0;
        end
    end

    function automatic logic [1:0] first_ch(input logic s, input logic b);
        first_ch = s ? `PMCE_CH_SHUNT : (b ? `PMCE_CH_BUS : `PMCE_CH_TEMP);
    endfunction

    assign last_sample = (n_q + 11'h001 >= cfg_avg_count);
    assign done_shunt = adc_done && state_q == pmce_pkg::PMCE_ST_WAIT
        && ch_q == `PMCE_CH_SHUNT;
    assign done_bus = adc_done && state_q == pmce_pkg::PMCE_ST_WAIT
        && ch_q == `PMCE_CH_BUS;
    assign done_temp = adc_done && state_q == pmce_pkg::PMCE_ST_WAIT
        && ch_q == `PMCE_CH_TEMP;
    assign load = adc_done && state_q == pmce_pkg::PMCE_ST_WAIT
        && last_ch && last_sample;
    assign clr_avg = cfg_write || load;

    // Start pulse leaves in the same cycle the state enters conversion
    assign adc_start = (state_q == pmce_pkg::PMCE_ST_CONV);
    assign adc_sel = ch_q;

    // Sequencer: one input at a time through the shared ADC
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= pmce_pkg::PMCE_ST_IDLE;
            ch_q <= `PMCE_CH_SHUNT;
            n_q <= '0;
        end
        else if (cfg_write)
        begin
            // A config write restarts any sequence in progress
            state_q <= any_en ? pmce_pkg::PMCE_ST_CONV
                              : pmce_pkg::PMCE_ST_IDLE;
            ch_q <= first_ch(cfg_en_shunt, cfg_en_bus);
            n_q <= '0;
        end
        else
        begin
            case (state_q)
                pmce_pkg::PMCE_ST_IDLE:
                    state_q <= pmce_pkg::PMCE_ST_IDLE;
                pmce_pkg::PMCE_ST_CONV:
                    state_q <= pmce_pkg::PMCE_ST_WAIT;
                pmce_pkg::PMCE_ST_WAIT:
                    if (adc_done)
                    begin
                        if (!last_ch)
                        begin
                            ch_q <= ch_next;
                            state_q <= pmce_pkg::PMCE_ST_CONV;
                        end
                        else
                        begin
                            ch_q <= first_ch(cfg_en_shunt, cfg_en_bus);
                            n_q <= last_sample ? '0 : n_q + 11'h001;
                            // Triggered mode stops after one full average
                            if (last_sample && !cfg_continuous)
                                state_q <= pmce_pkg::PMCE_ST_IDLE;
                            else
                                state_q <= pmce_pkg::PMCE_ST_CONV;
                        end
                    end
                default:
                    state_q <= pmce_pkg::PMCE_ST_IDLE;
            endcase
        end
    end

    // Per-sample current and power from the latest results
    assign cur_prod = 48'(adc_data) * $signed({33'h0, shunt_cal});
    assign cur_sample = cur_prod[`PMCE_CUR_W-1:0];
    assign bus_sample = `PMCE_CUR_W'(adc_data);
    assign tmp_sample = `PMCE_CUR_W'(adc_data);
    // Power magnitude; current taken from the previous shunt result
    assign pwr_prod = 48'(cur_now_q < 0 ? -cur_now_q : cur_now_q)
        * 48'(bus_sample < 0 ? -bus_sample : bus_sample);
    assign pwr_mean_prod = 48'(cur_mean < 0 ? -cur_mean : cur_mean)
        * 48'(bus_mean < 0 ? -bus_mean : bus_mean);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cur_now_q <= `PMCE_RESULT_RST;
        else if (done_shunt)
            cur_now_q <= cur_sample;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr_now_q <= `PMCE_RESULT_RST;
        else if (done_bus)
            pwr_now_q <= cal_zero ? '0 : pwr_prod[`PMCE_PWR_W-1:0];
    end

    // Averaging registers, one per quantity; count of one passes through
    pmce_avg_acc u_avg_cur (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(clr_avg),
        .add(done_shunt),
        .sample(cur_sample),
        .count(cfg_avg_count),
        .mean(cur_mean)
    );
    pmce_avg_acc u_avg_bus (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(clr_avg),
        .add(done_bus),
        .sample(bus_sample),
        .count(cfg_avg_count),
        .mean(bus_mean)
    );
    pmce_avg_acc u_avg_tmp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(clr_avg),
        .add(done_temp),
        .sample(tmp_sample),
        .count(cfg_avg_count),
        .mean(tmp_mean)
    );

    // Output registers change only at the end of a full round
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            current_out <= `PMCE_RESULT_RST;
            vbus_out <= `PMCE_RESULT_RST;
            temp_out <= `PMCE_RESULT_RST;
            power_out <= `PMCE_RESULT_RST;
        end
        else if (load)
        begin
            // Mean of a count of one equals the sample itself
            if (cfg_en_shunt)
                current_out <= cur_mean;
            if (cfg_en_bus)
                vbus_out <= bus_mean;
            if (cfg_en_temp)
                temp_out <= tmp_mean;
            power_out <= cal_zero ? '0
                : pwr_mean_prod[`PMCE_PWR_W-1:0];
        end
    end

    // Accumulate per conversion; no averaging, no extra sequencing
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            charge_out <= `PMCE_ACC_RST;
        else if (cfg_write || cal_zero)
            charge_out <= `PMCE_ACC_RST;
        else if (done_shunt)
            charge_out <= charge_out + `PMCE_ACC_W'(cur_sample);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            energy_out <= `PMCE_ACC_RST;
        else if (cfg_write || cal_zero)
            energy_out <= `PMCE_ACC_RST;
        else if (done_bus)
            // Power of this bus sample, not the one stored before it
            energy_out <= energy_out
                + `PMCE_ACC_W'(pwr_prod[`PMCE_PWR_W-1:0]);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            accum_valid <= 1'b0;
        else if (cfg_write)
            accum_valid <= cfg_continuous;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            conversion_done_flag <= 1'b0;
        else if (load)
            conversion_done_flag <= 1'b1;
        else if (cfg_write || flag_read)
            conversion_done_flag <= 1'b0;
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_done_on_load: assert property (load |=> conversion_done_flag)
        else $error("done flag not set after load");
    a_flag_cause: assert property ($rose(conversion_done_flag)
        |-> $past(load))
        else $error("done flag set without load");
    a_out_hold: assert property (!load |=> $stable(current_out)
        && $stable(power_out))
        else $error("outputs changed outside load");
    a_zero_cal: assert property (cal_zero && !cfg_write ##1 cal_zero
        |-> power_out == '0 || $past(power_out) != '0 && !$past(load))
        else $error("power nonzero with zero calibration");
    a_zero_acc: assert property (cal_zero |=> energy_out == '0
        && charge_out == '0)
        else $error("accumulators nonzero with zero calibration");
    // A config write may restart a conversion that has just been started
    a_one_adc: assert property (adc_start && !cfg_write |=> !adc_start)
        else $error("ADC started twice");
    a_charge_step: assert property (done_shunt && !cal_zero
        && !cfg_write |=> charge_out
        == $past(charge_out) + `PMCE_ACC_W'($past(cur_sample)))
        else $error("charge did not add current");
    a_trig_stop: assert property (load && !cfg_continuous
        && !cfg_write |=> state_q == pmce_pkg::PMCE_ST_IDLE [*2])
        else $error("triggered run did not stop");
    a_shunt_cur: assert property (done_shunt
        |=> cur_now_q == $past(cur_sample))
        else $error("current not updated after shunt");
    c_load: cover property (load);
    c_avg: cover property (load && cfg_avg_count > `PMCE_CNT_ONE);
    c_flag_clr: cover property (conversion_done_flag
        ##1 !conversion_done_flag);
endmodule

// ### pmce_adc_model.sv
/*
 * Behavioural model of the shared multiplexed converter that feeds the
 * calculation engine. Each channel yields base + step * n, where n counts
 * that channel's conversions since the last rewind.
 * Assumes same-clock handshake: adc_start sampled at a rising edge, then
 * adc_done pulses for one cycle after lat edges.
 */
`include "pmce_cfg.svh"

module pmce_adc_model #(
    parameter int SH = -100,
    parameter int BU = 200,
    parameter int TE = 50,
    parameter int STEP = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rewind,
    input wire logic adc_start,
    input wire logic [1:0] adc_sel,
    input wire logic [7:0] lat,
    output logic adc_done,
    output logic signed [`PMCE_ADC_W-1:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic [7:0] cnt_q;
    logic [1:0] ch_q;
    int k_q [3];
    int base;

    always_comb
    begin
        case (ch_q)
            2'h0: base = SH;
            2'h1: base = BU;
            default: base = TE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            ch_q <= 2'h0;
            adc_done <= 1'b0;
            adc_data <= 20'h00000;
            k_q <= '{default: 0};
        end
        else
        begin
            adc_done <= 1'b0;
            // Data is only meaningful with done; scramble it otherwise
            adc_data <= ~adc_data;
            if (adc_start)
            begin
                // A new start aborts any conversion still in flight
                busy_q <= 1'b1;
                cnt_q <= lat;
                ch_q <= adc_sel;
            end
            else if (busy_q)
            begin
                if (cnt_q <= 8'h01)
                begin
                    adc_done <= 1'b1;
                    adc_data <= 20'(base + STEP * k_q[ch_q]);
                    busy_q <= 1'b0;
                    k_q[ch_q] <= k_q[ch_q] + 1;
                end
                else
                    cnt_q <= cnt_q - 8'h01;
            end
            if (rewind)
                k_q <= '{default: 0};
        end
    end
endmodule

// ### testbench.sv
/*
 * Self-checking bench for the calculation engine with a converter model.
 * Assumes the model's sample series restarts on every configuration write.
 */
`include "pmce_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t value mismatch", $time); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SH = -100;
    localparam int BU = 200;
    localparam int TE = 50;
    localparam int ST = 2;
    localparam int CAL = 3;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_write = 1'b0;
    logic cfg_continuous = 1'b0;
    logic cfg_en_shunt = 1'b0;
    logic cfg_en_bus = 1'b0;
    logic cfg_en_temp = 1'b0;
    logic [`PMCE_AVG_W-1:0] cfg_avg_count = 11'h001;
    logic [`PMCE_CAL_W-1:0] shunt_cal = 15'h0000;
    logic flag_read = 1'b0;
    logic [7:0] lat = 8'h01;
    logic adc_start, adc_done, accum_valid, conversion_done_flag;
    logic [1:0] adc_sel;
    logic signed [`PMCE_ADC_W-1:0] adc_data;
    logic signed [`PMCE_CUR_W-1:0] current_out, vbus_out, temp_out;
    logic [`PMCE_PWR_W-1:0] power_out;
    logic signed [`PMCE_ACC_W-1:0] energy_out, charge_out;
    int n_fail = 0;
    int cmp_count = 0;
    logic [1:0] sel_q [$];

    always #10 ref_clk = ~ref_clk;

    pmce_engine pmce_engine_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .cfg_write(cfg_write), .cfg_continuous(cfg_continuous),
        .cfg_en_shunt(cfg_en_shunt), .cfg_en_bus(cfg_en_bus),
        .cfg_en_temp(cfg_en_temp), .cfg_avg_count(cfg_avg_count),
        .shunt_cal(shunt_cal), .flag_read(flag_read),
        .adc_start(adc_start), .adc_sel(adc_sel), .adc_done(adc_done),
        .adc_data(adc_data), .current_out(current_out),
        .vbus_out(vbus_out), .temp_out(temp_out), .power_out(power_out),
        .energy_out(energy_out), .charge_out(charge_out),
        .accum_valid(accum_valid),
        .conversion_done_flag(conversion_done_flag));

    pmce_adc_model #(.SH(SH), .BU(BU), .TE(TE), .STEP(ST))
        pmce_adc_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .rewind(cfg_write), .adc_start(adc_start), .adc_sel(adc_sel),
        .lat(lat), .adc_done(adc_done), .adc_data(adc_data));

    always @(posedge ref_clk)
        if (adc_start === 1'b1)
            sel_q.push_back(adc_sel);

    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cfg(input logic cont, input logic [2:0] en,
        input logic [10:0] avg, input logic [14:0] cal, input logic [7:0] l);
        @(posedge ref_clk);
        cfg_continuous <= cont;
        {cfg_en_shunt, cfg_en_bus, cfg_en_temp} <= en;
        cfg_avg_count <= avg;
        shunt_cal <= cal;
        lat <= l;
        cfg_write <= 1'b1;
        @(posedge ref_clk);
        cfg_write <= 1'b0;
        // Drop any start logged from the sequence being replaced
        #1 sel_q.delete();
    endtask

    task automatic wait_flag(output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        while (conversion_done_flag !== 1'b1 && n < 3000);
        `CHK(conversion_done_flag, 1'b1)
    endtask

    task automatic read_flag();
        @(posedge ref_clk);
        flag_read <= 1'b1;
        @(posedge ref_clk);
        flag_read <= 1'b0;
    endtask

    task automatic t_triggered();
        int n;
        cfg(1'b0, 3'b101, 11'h001, 15'(CAL), 8'h02);
        wait_flag(n);
        repeat (20) @(posedge ref_clk);
        #1 `CHK(sel_q.size(), 2)
        `CHK({sel_q[0], sel_q[1]}, 4'h2)
        `CHK(current_out, 24'(SH * CAL))
        `CHK(temp_out, 24'(TE))
        `CHK(vbus_out, 24'h000000)
        `CHK(accum_valid, 1'b0)
        `CHK(conversion_done_flag, 1'b1)
        read_flag();
        #1 `CHK(conversion_done_flag, 1'b0)
    endtask

    task automatic t_average();
        int n, d, ik, si, se, mi;
        si = 0;
        se = 0;
        d = 0;
        for (int k = 0; k < 4; k++)
        begin
            ik = (SH + ST * k) * CAL;
            si += ik;
            se += (ik < 0 ? -ik : ik) * (BU + ST * k);
        end
        mi = si / 4;
        cfg(1'b1, 3'b111, 11'h004, 15'(CAL), 8'h05);
        repeat (300)
            if (d < 3)
            begin
                @(posedge ref_clk);
                if (adc_done === 1'b1)
                    d++;
            end
        repeat (2) @(posedge ref_clk);
        #1 `CHK(conversion_done_flag, 1'b0)
        `CHK(current_out, 24'(SH * CAL))
        `CHK(vbus_out, 24'h000000)
        wait_flag(n);
        `CHK(current_out, 24'(mi))
        `CHK(vbus_out, 24'(BU + 3 * ST / 2))
        `CHK(temp_out, 24'(TE + 3 * ST / 2))
        `CHK(power_out, 24'(-mi * (BU + 3 * ST / 2)))
        `CHK(charge_out, 40'(si))
        `CHK(energy_out, 40'(se))
        `CHK(accum_valid, 1'b1)
        // Second round proves the current sum was cleared in between
        read_flag();
        wait_flag(n);
        `CHK(current_out, 24'((2 * SH + 11 * ST) * CAL / 2))
    endtask

    task automatic t_direct();
        int n, i;
        i = SH * CAL;
        cfg(1'b1, 3'b111, 11'h001, 15'(CAL), 8'h01);
        wait_flag(n);
        `CHK(n <= 11, 1'b1)
        `CHK({sel_q[0], sel_q[1], sel_q[2]}, 6'h06)
        `CHK(current_out, 24'(i))
        `CHK(vbus_out, 24'(BU))
        `CHK(power_out, 24'(-i * BU))
        `CHK(charge_out, 40'(i))
        `CHK(energy_out, 40'(-i * BU))
    endtask

    task automatic t_zero_cal();
        int n;
        cfg(1'b1, 3'b111, 11'h001, 15'h0000, 8'h01);
        wait_flag(n);
        `CHK(power_out, 24'h000000)
        `CHK(energy_out, 40'h0000000000)
        `CHK(charge_out, 40'h0000000000)
        `CHK(vbus_out, 24'(BU))
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_triggered();
        t_average();
        t_direct();
        t_zero_cal();
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
endmodule
